// >>> word_serial_servant_port_tb.sv
/* Self-checking bench of the servant port, driven through the commander model.
   Assumes a 25 MHz clock and the design's default parameters. */
`timescale 1ns/10ps
module word_serial_servant_port_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] la_i = 8'h18;
    logic modid_n_i = 1'b1;
    logic msg_ready_i = 1'b1;
    logic reply_valid_i = 1'b0;
    logic [7:0] reply_data_i = 8'h31;
    logic reply_end_i = 1'b1;
    logic as_n, ds0_n, ds1_n, write_n, iack_n, iackin_n, ok, taken;
    logic [5:0] am;
    logic [15:1] addr;
    logic [15:0] wdata, data_o, rd;
    logic data_oe_o, dtack_n_o, iackout_n_o, irq_n_o, sf_inhibit_o, trig_o;
    logic msg_valid_o, msg_end_o, reply_ready_o;
    logic [7:0] msg_data_o;
    logic [8:0] rxq[$];
    int error_cnt = 0;
    int checks = 0;
    int trig_cnt = 0;
    int chain_cnt = 0;
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (msg_valid_o === 1'b1 && msg_ready_i) rxq.push_back({msg_end_o, msg_data_o});
        if (trig_o === 1'b1) trig_cnt++;
        if (iackout_n_o === 1'b0) chain_cnt++;
        if (reply_valid_i && reply_ready_o === 1'b1) taken = 1'b1;
    end
    wss_commander cmd (.clk_i(clk_i), .dtack_n_i(dtack_n_o), .data_i(data_o),
        .as_n_o(as_n), .ds0_n_o(ds0_n), .ds1_n_o(ds1_n), .write_n_o(write_n),
        .iack_n_o(iack_n), .iackin_n_o(iackin_n), .am_o(am), .addr_o(addr), .data_o(wdata));
    wss_servant uut (.clk_i(clk_i), .rst_i(rst_i), .la_i(la_i), .modid_n_i(modid_n_i),
        .as_n_i(as_n), .ds0_n_i(ds0_n), .ds1_n_i(ds1_n), .write_n_i(write_n),
        .iack_n_i(iack_n), .iackin_n_i(iackin_n), .am_i(am), .addr_i(addr),
        .data_i(wdata), .data_o(data_o), .data_oe_o(data_oe_o), .dtack_n_o(dtack_n_o),
        .iackout_n_o(iackout_n_o), .irq_n_o(irq_n_o), .sf_inhibit_o(sf_inhibit_o),
        .trig_o(trig_o), .msg_valid_o(msg_valid_o), .msg_data_o(msg_data_o),
        .msg_end_o(msg_end_o), .msg_ready_i(msg_ready_i), .reply_valid_i(reply_valid_i),
        .reply_data_i(reply_data_i), .reply_end_i(reply_end_i),
        .reply_ready_o(reply_ready_o));
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        chk16(n, {15'h0, e}, {15'h0, g});
    endtask
    // Offsets are relative to the block that the switches select
    task automatic acc(input logic wr, input logic [15:0] off, input logic [15:0] wd);
        cmd.access(wr, 1'b0, 6'h29, 16'hc000 + {2'h0, la_i, 6'h00} + off, wd, rd, ok);
    endtask
    // Commander polls the response word before every command
    task automatic wait_bit(input int b);
        int n;
        n = 0;
        acc(1'b0, 16'h000a, 16'h0000);
        while (rd[b] !== 1'b1 && n < 40) begin
            acc(1'b0, 16'h000a, 16'h0000);
            n++;
        end
        chk1("ready bit", 1'b1, rd[b]);
    endtask
    task automatic send(input logic [7:0] b, input logic e);
        wait_bit(9);
        acc(1'b1, 16'h000e, {e ? 8'hbd : 8'hbc, b});
    endtask
    task automatic t_regs();
        acc(1'b0, 16'h0000, 16'h0000);
        chk16("ident", 16'h1234, rd);
        acc(1'b0, 16'h0002, 16'h0000);
        chk16("model", 16'h5678, rd);
        acc(1'b0, 16'h0008, 16'h0000);
        chk16("protocol", 16'hefff, rd);
        acc(1'b0, 16'h0004, 16'h0000);
        chk16("status", {1'b0, modid_n_i, 14'h3ff3}, rd & 16'hfff3);
        acc(1'b1, 16'h0000, 16'h0000);
        acc(1'b0, 16'h0000, 16'h0000);
        chk16("ident kept", 16'h1234, rd);
        acc(1'b0, 16'h0006, 16'h0000);
        chk16("offset 6", 16'h0000, rd);
        acc(1'b0, 16'h000c, 16'h0000);
        chk16("offset c", 16'h0000, rd);
        acc(1'b0, 16'h000a, 16'h0000);
        chk16("response", 16'hfbff, rd);
        $display("test regs done");
    endtask
    task automatic t_decode();
        cmd.access(1'b0, 1'b0, 6'h39, 16'hc600, 16'h0000, rd, ok);
        chk1("foreign modifier", 1'b0, ok);
        acc(1'b0, 16'h0040, 16'h0000);
        chk1("past block", 1'b0, ok);
        la_i = 8'h03;
        cmd.access(1'b0, 1'b0, 6'h2d, 16'hc0c0, 16'h0000, rd, ok);
        chk16("moved ident", 16'h1234, rd);
        cmd.access(1'b0, 1'b0, 6'h29, 16'hc600, 16'h0000, rd, ok);
        chk1("old base", 1'b0, ok);
        la_i = 8'h18;
        $display("test decode done");
    endtask
    task automatic t_fifo();
        int n;
        n = 0;
        msg_ready_i = 1'b0;
        rxq.delete();
        for (int i = 0; i < 40; i++) begin
            acc(1'b0, 16'h000a, 16'h0000);
            if (rd[9] !== 1'b1) break;
            acc(1'b1, 16'h000e, {8'hbc, i[7:0]});
            n++;
        end
        chk16("buffer refuses", 16'h0022, 16'(n));
        msg_ready_i = 1'b1;
        send(8'h41, 1'b1);
        repeat (60) @(negedge clk_i);
        chk16("drained", 16'(n + 1), 16'(rxq.size()));
        for (int i = 0; i < n; i++) chk16("byte", {7'h0, i[8:0]}, {7'h0, rxq[i]});
        chk16("end byte", 16'h0141, {7'h0, rxq[n]});
        $display("test fifo done");
    endtask
    task automatic t_query();
        logic seen;
        int t;
        seen = 1'b0;
        taken = 1'b0;
        rxq.delete();
        reply_valid_i = 1'b1;
        send(8'h51, 1'b0);
        wait_bit(9);
        acc(1'b1, 16'h000e, 16'hdeff);
        repeat (20) @(negedge clk_i) seen |= (reply_ready_o === 1'b1);
        chk1("withheld", 1'b0, seen);
        // Request is stuck without a terminator; the control reset frees it
        acc(1'b1, 16'h0004, 16'h0003);
        chk1("inhibit", 1'b1, sf_inhibit_o);
        send(8'h0d, 1'b0);
        send(8'h0a, 1'b1);
        wait_bit(9);
        acc(1'b1, 16'h000e, 16'hdeff);
        for (int i = 0; i < 100 && !taken; i++) @(negedge clk_i);
        reply_valid_i = 1'b0;
        chk1("reply taken", 1'b1, taken);
        wait_bit(10);
        chk1("irq raised", 1'b0, irq_n_o);
        cmd.access(1'b0, 1'b1, 6'h29, 16'h0002, 16'h0000, rd, ok);
        chk16("status id", {8'hfd, la_i}, rd);
        chk1("irq cleared", 1'b1, irq_n_o);
        t = chain_cnt;
        cmd.access(1'b0, 1'b1, 6'h29, 16'h0002, 16'h0000, rd, ok);
        chk1("chain passed", 1'b1, !ok && chain_cnt > t);
        acc(1'b0, 16'h000e, 16'h0000);
        chk16("reply", 16'h0131, rd);
        acc(1'b0, 16'h000a, 16'h0000);
        chk16("after read", 16'hfbff, rd);
        $display("test query done");
    endtask
    task automatic t_proto();
        int t;
        wait_bit(9);
        acc(1'b1, 16'h000e, 16'hcfff);
        wait_bit(10);
        acc(1'b0, 16'h000e, 16'h0000);
        chk16("capability", 16'hff6b, rd);
        chk1("no irq", 1'b1, irq_n_o);
        wait_bit(9);
        t = trig_cnt;
        acc(1'b1, 16'h000e, 16'hedff);
        repeat (5) @(negedge clk_i);
        chk16("trigger", 16'h0001, 16'(trig_cnt - t));
        $display("test proto done");
    endtask
    initial begin
        repeat (5) @(negedge clk_i);
        rst_i = 1'b0;
        t_regs();
        t_decode();
        t_fifo();
        t_query();
        t_proto();
        conclude();
    end
    // Whole run takes under a thousand cycles; this bound of 50000 cycles is far above it
    initial begin
        #2000000;
        error_cnt++;
        conclude();
    end
endmodule

// >>> wss_commander.sv
/* Backplane commander model: one word access or acknowledge cycle per call.
   Assumes the bench calls access and feeds back acknowledge and read data. */
`timescale 1ns/10ps
module wss_commander (
    input wire logic clk_i,          // Clock
    input wire logic dtack_n_i,      // Acknowledge
    input wire logic [15:0] data_i,  // Read data
    output logic as_n_o,             // Address strobe
    output logic ds0_n_o,            // Data strobe low
    output logic ds1_n_o,            // Data strobe high
    output logic write_n_o,          // Write
    output logic iack_n_o,           // Acknowledge cycle
    output logic iackin_n_o,         // Chain in
    output logic [5:0] am_o,         // Address modifier
    output logic [15:1] addr_o,      // Address
    output logic [15:0] data_o       // Write data
);
    initial begin
        {as_n_o, ds0_n_o, ds1_n_o, write_n_o, iack_n_o, iackin_n_o} = 6'h3f;
        am_o = 6'h29;
        addr_o = 15'h0000;
        data_o = 16'h0000;
    end
    // Released data lines show the inverse so a stale value never matches
    task automatic access(input logic wr, input logic ack, input logic [5:0] am,
            input logic [15:0] a, input logic [15:0] wd, output logic [15:0] rd,
            output logic ok);
        int n;
        rd = 16'hxxxx;
        ok = 1'b0;
        n = 0;
        @(negedge clk_i);
        addr_o = a[15:1];
        am_o = am;
        write_n_o = !wr;
        iack_n_o = !ack;
        iackin_n_o = !ack;
        data_o = wr ? wd : ~data_o;
        as_n_o = 1'b0;
        ds0_n_o = 1'b0;
        ds1_n_o = ack;
        while (!ok && n < 8) begin
            @(posedge clk_i);
            n++;
            if (dtack_n_i === 1'b0) begin
                ok = 1'b1;
                rd = data_i;
            end
        end
        @(negedge clk_i);
        {as_n_o, ds0_n_o, ds1_n_o, write_n_o, iack_n_o, iackin_n_o} = 6'h3f;
        data_o = ~data_o;
        repeat (3) @(negedge clk_i);
    endtask
endmodule

// >>> wss_consts.svh
/*
 Constants of the word-serial servant port: register offsets, fixed register
 values, command codes and backplane address-modifier codes.
 Assumes inclusion by bare name from wss_servant and wss_term_det.
*/
`ifndef WSS_CONSTS_SVH
`define WSS_CONSTS_SVH

`define WSS_OFS_IDENT 5'h00
`define WSS_OFS_MODEL 5'h02
`define WSS_OFS_STATE 5'h04
`define WSS_OFS_WINBASE 5'h06
`define WSS_OFS_PROTO 5'h08
`define WSS_OFS_REPLY 5'h0a
`define WSS_OFS_UPPER 5'h0c
`define WSS_OFS_DLOW 5'h0e

`define WSS_BLOCK_BASE 16'hc000
`define WSS_PROTO_VALUE 16'hefff
`define WSS_CAPABILITY 16'hff6b
`define WSS_REPLY_IDLE 16'hf9ff
`define WSS_REPLY_RR_BIT 10
`define WSS_REPLY_WR_BIT 9
`define WSS_CTRL_RESET_BIT 0
`define WSS_CTRL_SFINH_BIT 1

`define WSS_CMD_BYTE_AVAIL 8'hbc
`define WSS_CMD_BYTE_AVAIL_END 8'hbd
`define WSS_CMD_BYTE_REQ 16'hdeff
`define WSS_CMD_READ_PROTO 16'hcfff
`define WSS_CMD_TRIGGER 16'hedff
`define WSS_CMD_CLEAR 16'hffff

`define WSS_AM_A16_USER 6'h29
`define WSS_AM_A16_SUPER 6'h2d
`define WSS_STATID_CAUSE 8'hfd

`define WSS_CHAR_CR 8'h0d
`define WSS_CHAR_LF 8'h0a

`endif

// >>> wss_fifo.sv
/*
 Synchronous FIFO with a registered output stage; valid/ready on both sides.
 Assumes one clock and a synchronous active-high reset; flush empties it.
*/
`timescale 1ns/10ps
module wss_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,               // Clock
    input wire logic rst_i,               // Synchronous reset
    input wire logic flush_i,             // Drop all content
    input wire logic in_valid_i,          // Word offered
    input wire logic [WIDTH-1:0] in_data_i, // Word offered
    output logic in_ready_o,              // Room for a word
    output logic out_valid_o,             // Output word valid
    output logic [WIDTH-1:0] out_data_o,  // Output word
    input wire logic out_ready_i          // Drain side takes word
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic ov;
        logic [WIDTH-1:0] od;
    } wss_fifo_st_t;

    wss_fifo_st_t s_r;
    wss_fifo_st_t s_nxt;
    logic push;
    logic take;

    assign in_ready_o = (s_r.cnt < (AW+1)'(DEPTH));
    assign out_valid_o = s_r.ov;
    assign out_data_o = s_r.od;

    always_comb begin
        s_nxt = s_r;
        push = in_valid_i && in_ready_o;
        take = (!s_r.ov || out_ready_i) && (s_r.cnt != '0);
        if (push) begin
            s_nxt.mem[s_r.wp] = in_data_i;
            s_nxt.wp = s_r.wp + AW'(1);
        end
        if (take) begin
            s_nxt.od = s_r.mem[s_r.rp];
            s_nxt.rp = s_r.rp + AW'(1);
        end
        if (!s_r.ov || out_ready_i) begin
            s_nxt.ov = take;
        end
        s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(take);
        if (flush_i) begin
            s_nxt.wp = '0;
            s_nxt.rp = '0;
            s_nxt.cnt = '0;
            s_nxt.ov = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// >>> wss_pkg.sv
/*
 Types shared by the word-serial servant port.
 Assumes the constants header sits in the same folder.
*/
package wss_pkg;

typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_HOLD
} wss_bus_st_t;

typedef enum logic [1:0] {
    MSG_IDLE,
    MSG_PUSH,
    MSG_WAIT,
    MSG_HOLD
} wss_msg_st_t;

typedef struct packed {
    wss_bus_st_t bus;
    wss_msg_st_t msg;
    logic [15:0] rdata;
    logic data_oe;
    logic dtack;
    logic iack_out;
    logic irq;
    logic wr_rdy;
    logic rd_rdy;
    logic [15:0] dlow;
    logic [8:0] push_word;
    logic reply_rdy;
    logic soft_rst;
    logic sf_inhibit;
    logic trig;
} wss_state_t;

endpackage

// >>> wss_servant.sv
/*
 Message-based word-serial servant on a short-address, 16-bit backplane:
 configuration registers, base decode from the address switches, normal
 transfer handshake, status/ID interrupter, and the byte streams to and from
 the module's command logic.
 Assumes backplane strobes already synchronous to clk_i, one clock, and
 word-wide (both data strobes) accesses.
*/
`timescale 1ns/10ps
`include "wss_consts.svh"
module wss_servant #(
    parameter logic [15:0] IDENT_WORD = 16'h1234, // Arbitrary maker code
    parameter logic [15:0] MODEL_WORD = 16'h5678, // Arbitrary model code
    parameter logic [2:0] IRQ_LEVEL = 3'h1,       // Interrupt line used
    parameter int FIFO_DEPTH = 32                 // Inbound byte buffer
) (
    input wire logic clk_i,              // 25 MHz clock
    input wire logic rst_i,              // Synchronous reset
    input wire logic [7:0] la_i,         // Logical address switches
    input wire logic modid_n_i,          // Module-identify line
    input wire logic as_n_i,             // Address strobe
    input wire logic ds0_n_i,            // Data strobe, low byte
    input wire logic ds1_n_i,            // Data strobe, high byte
    input wire logic write_n_i,          // Low for write
    input wire logic iack_n_i,           // Interrupt acknowledge cycle
    input wire logic iackin_n_i,         // Acknowledge daisy chain in
    input wire logic [5:0] am_i,         // Address modifier
    input wire logic [15:1] addr_i,      // Word address
    input wire logic [15:0] data_i,      // Data from bus
    output logic [15:0] data_o,          // Data to bus
    output logic data_oe_o,              // Drive data lines
    output logic dtack_n_o,              // Acknowledge, active low
    output logic iackout_n_o,            // Acknowledge daisy chain out
    output logic irq_n_o,                // Interrupt request, active low
    output logic sf_inhibit_o,           // Failure-line inhibit from control
    output logic trig_o,                 // Trigger command pulse
    output logic msg_valid_o,            // Received byte valid
    output logic [7:0] msg_data_o,       // Received byte
    output logic msg_end_o,              // Byte carried the end flag
    input wire logic msg_ready_i,        // Command logic takes byte
    input wire logic reply_valid_i,      // Reply byte offered
    input wire logic [7:0] reply_data_i, // Reply byte
    input wire logic reply_end_i,        // Last byte of reply
    output logic reply_ready_o           // Reply byte taken
);
    wss_pkg::wss_state_t s_r;
    wss_pkg::wss_state_t s_nxt;

    logic rx_ready;
    logic rx_valid;
    logic [8:0] rx_out;
    logic term_seen;
    logic strobes;
    logic released;
    logic space_ok;
    logic block_hit;
    logic [4:0] ofs;
    logic iack_ours;
    logic [15:0] rd_word;
    logic [15:0] reply_word;
    logic [15:0] state_word;
    logic push_fire;

    wss_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .flush_i(s_r.soft_rst),
        .in_valid_i(rx_valid),
        .in_data_i(s_r.push_word),
        .in_ready_o(rx_ready),
        .out_valid_o(msg_valid_o),
        .out_data_o(rx_out),
        .out_ready_i(msg_ready_i)
    );

    assign msg_data_o = rx_out[7:0];
    assign msg_end_o = rx_out[8];

    wss_term_det u_term (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(s_r.soft_rst),
        .byte_valid_i(push_fire),
        .byte_i(s_r.push_word[7:0]),
        .term_o(term_seen)
    );

    assign rx_valid = (s_r.msg == wss_pkg::MSG_PUSH);
    assign push_fire = rx_valid && rx_ready;

    assign data_o = s_r.rdata;
    assign data_oe_o = s_r.data_oe;
    assign dtack_n_o = !s_r.dtack;
    assign iackout_n_o = !s_r.iack_out;
    assign irq_n_o = !s_r.irq;
    assign sf_inhibit_o = s_r.sf_inhibit;
    assign trig_o = s_r.trig;
    assign reply_ready_o = s_r.reply_rdy;

    always_comb begin
        strobes = !as_n_i && !ds0_n_i && !ds1_n_i;
        released = ds0_n_i && ds1_n_i;
        space_ok = (am_i == `WSS_AM_A16_USER) || (am_i == `WSS_AM_A16_SUPER);
        // Block base is switches * 40h + C000h; the block spans 64 bytes
        block_hit = ({addr_i[15:6], 6'h00} == (`WSS_BLOCK_BASE + {2'b00, la_i, 6'h00}));
        // Upper half of the block maps to no register, so it never aliases one
        ofs = addr_i[5] ? 5'h1f : {addr_i[4:1], 1'b0};
        iack_ours = !iack_n_i && !iackin_n_i && (addr_i[3:1] == IRQ_LEVEL) && s_r.irq;
        state_word = {1'b0, modid_n_i, 10'h3ff, !s_r.soft_rst, !s_r.soft_rst, 2'b11};
        reply_word = `WSS_REPLY_IDLE;
        reply_word[`WSS_REPLY_RR_BIT] = s_r.rd_rdy;
        reply_word[`WSS_REPLY_WR_BIT] = s_r.wr_rdy;
        // Undefined and write-only locations answer but read as zero
        case (ofs)
            `WSS_OFS_IDENT: rd_word = IDENT_WORD;
            `WSS_OFS_MODEL: rd_word = MODEL_WORD;
            `WSS_OFS_STATE: rd_word = state_word;
            `WSS_OFS_PROTO: rd_word = `WSS_PROTO_VALUE;
            `WSS_OFS_REPLY: rd_word = reply_word;
            `WSS_OFS_DLOW: rd_word = s_r.dlow;
            default: rd_word = 16'h0000;
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.trig = 1'b0;
        s_nxt.soft_rst = 1'b0;

        // Bus slave: the port only answers, it never starts a cycle
        case (s_r.bus)
            wss_pkg::BUS_IDLE: begin
                if (iack_ours && !as_n_i && !ds0_n_i) begin
                    s_nxt.rdata = {`WSS_STATID_CAUSE, la_i};
                    s_nxt.data_oe = 1'b1;
                    s_nxt.dtack = 1'b1;
                    s_nxt.irq = 1'b0;
                    s_nxt.bus = wss_pkg::BUS_HOLD;
                end else if (!iack_n_i && !iackin_n_i && !as_n_i && !iack_ours) begin
                    // Not our level or nothing pending: hand the chain on
                    s_nxt.iack_out = 1'b1;
                end else if (strobes && iack_n_i && space_ok && block_hit) begin
                    s_nxt.dtack = 1'b1;
                    s_nxt.bus = wss_pkg::BUS_HOLD;
                    if (write_n_i) begin
                        s_nxt.rdata = rd_word;
                        s_nxt.data_oe = 1'b1;
                        if (ofs == `WSS_OFS_DLOW && s_r.msg == wss_pkg::MSG_HOLD) begin
                            s_nxt.rd_rdy = 1'b0;
                            s_nxt.wr_rdy = 1'b1;
                            s_nxt.msg = wss_pkg::MSG_IDLE;
                        end
                    end else if (ofs == `WSS_OFS_STATE) begin
                        s_nxt.sf_inhibit = data_i[`WSS_CTRL_SFINH_BIT];
                        s_nxt.soft_rst = data_i[`WSS_CTRL_RESET_BIT];
                    end else if (ofs == `WSS_OFS_DLOW && s_r.wr_rdy) begin
                        // Byte, request and protocol-read commands take write-ready away
                        s_nxt.wr_rdy = 1'b0;
                        if (data_i[15:8] == `WSS_CMD_BYTE_AVAIL ||
                            data_i[15:8] == `WSS_CMD_BYTE_AVAIL_END) begin
                            s_nxt.push_word = {data_i[8], data_i[7:0]};
                            s_nxt.msg = wss_pkg::MSG_PUSH;
                        end else if (data_i == `WSS_CMD_BYTE_REQ) begin
                            s_nxt.msg = wss_pkg::MSG_WAIT;
                        end else if (data_i == `WSS_CMD_READ_PROTO) begin
                            s_nxt.dlow = `WSS_CAPABILITY;
                            s_nxt.rd_rdy = 1'b1;
                            s_nxt.msg = wss_pkg::MSG_HOLD;
                        end else begin
                            // Trigger, clear and unknown commands finish at once
                            s_nxt.trig = (data_i == `WSS_CMD_TRIGGER);
                            s_nxt.soft_rst = (data_i == `WSS_CMD_CLEAR);
                            s_nxt.wr_rdy = 1'b1;
                        end
                    end
                    // Other writes, including read-only offsets, are dropped
                end
                if (as_n_i) begin
                    s_nxt.iack_out = 1'b0;
                end
            end
            wss_pkg::BUS_HOLD: begin
                if (released) begin
                    s_nxt.dtack = 1'b0;
                    s_nxt.data_oe = 1'b0;
                    s_nxt.bus = wss_pkg::BUS_IDLE;
                end
            end
            default: begin
                s_nxt.bus = wss_pkg::BUS_IDLE;
            end
        endcase

        // Message side: back-pressure from the FIFO holds write-ready low
        case (s_r.msg)
            wss_pkg::MSG_PUSH: begin
                if (rx_ready) begin
                    s_nxt.msg = wss_pkg::MSG_IDLE;
                    s_nxt.wr_rdy = 1'b1;
                end
            end
            wss_pkg::MSG_WAIT: begin
                if (s_r.reply_rdy && reply_valid_i) begin
                    s_nxt.dlow = {7'h00, reply_end_i, reply_data_i};
                    s_nxt.rd_rdy = 1'b1;
                    s_nxt.irq = 1'b1;
                    s_nxt.reply_rdy = 1'b0;
                    s_nxt.msg = wss_pkg::MSG_HOLD;
                end else begin
                    s_nxt.reply_rdy = term_seen;
                end
            end
            wss_pkg::MSG_IDLE: begin
                s_nxt.reply_rdy = 1'b0;
            end
            wss_pkg::MSG_HOLD: begin
                s_nxt.reply_rdy = 1'b0;
            end
            default: begin
                s_nxt.msg = wss_pkg::MSG_IDLE;
            end
        endcase

        if (s_r.soft_rst) begin
            s_nxt.msg = wss_pkg::MSG_IDLE;
            s_nxt.wr_rdy = 1'b1;
            s_nxt.rd_rdy = 1'b0;
            s_nxt.reply_rdy = 1'b0;
            s_nxt.irq = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
            s_r.wr_rdy <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// >>> wss_servant_monitor.sv
/* Checker of the servant port's bus answers and reply timing.
   Assumes a bind onto wss_servant; watches its ports only. */
`timescale 1ns/10ps
module wss_servant_monitor (
    input wire logic clk_i,           // Clock
    input wire logic rst_i,           // Reset
    input wire logic [7:0] la_i,      // Address switches
    input wire logic as_n_i,          // Address strobe
    input wire logic ds0_n_i,         // Data strobe low
    input wire logic ds1_n_i,         // Data strobe high
    input wire logic write_n_i,       // Write
    input wire logic iack_n_i,        // Acknowledge cycle
    input wire logic [5:0] am_i,      // Address modifier
    input wire logic [15:1] addr_i,   // Address
    input wire logic [15:0] data_o,   // Read data
    input wire logic data_oe_o,       // Data drive
    input wire logic dtack_n_o,       // Acknowledge
    input wire logic irq_n_o,         // Interrupt
    input wire logic trig_o,          // Trigger pulse
    input wire logic reply_valid_i,   // Reply offered
    input wire logic reply_ready_o    // Reply taken
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic [15:0] base_w;
    assign base_w = 16'hc000 + {2'h0, la_i, 6'h00};
    sequence ans_s;
        $fell(dtack_n_o) && $past(iack_n_i);
    endsequence
    property rd_p(logic [4:0] o, logic [15:0] v);
        ans_s ##0 $past(write_n_i) && $past(addr_i[5:1]) == o |-> data_o == v;
    endproperty
    AST_AM: assert property (ans_s |-> $past(am_i) inside {6'h29, 6'h2d})
        else $error("answer to a foreign address modifier");
    AST_BASE: assert property (ans_s |-> $past(addr_i[15:6]) == $past(base_w[15:6]))
        else $error("answer outside the switch block");
    AST_PROTO: assert property (rd_p(5'h04, 16'hefff))
        else $error("protocol word wrong");
    AST_UNDEF: assert property (rd_p(5'h06, 16'h0000))
        else $error("undefined offset returned data");
    AST_RESP: assert property (ans_s ##0 $past(write_n_i) && $past(addr_i[5:1]) == 5'h05
        |-> (data_o | 16'h0600) == 16'hffff)
        else $error("response fixed bits wrong");
    AST_IACK: assert property ($fell(dtack_n_o) && !$past(iack_n_i)
        |-> data_o == {8'hfd, $past(la_i)} && data_oe_o)
        else $error("status word wrong");
    AST_WROE: assert property (!dtack_n_o && !write_n_i && iack_n_i |-> !data_oe_o)
        else $error("data driven during a write");
    AST_HOLD: assert property (!dtack_n_o && !as_n_i && !ds0_n_i && !ds1_n_i
        |=> !dtack_n_o)
        else $error("acknowledge dropped under strobes");
    AST_IRQ: assert property ($fell(irq_n_o) |-> $past(reply_valid_i && reply_ready_o)
        || $past(reply_valid_i && reply_ready_o, 2))
        else $error("interrupt without a loaded reply");
    AST_TRIG: assert property ($rose(trig_o) |=> !trig_o)
        else $error("trigger pulse too long");
    cover property ($fell(irq_n_o));
    cover property ($fell(dtack_n_o) && !$past(iack_n_i));
    cover property (reply_valid_i && reply_ready_o);
endmodule

bind wss_servant wss_servant_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .la_i(la_i),
    .as_n_i(as_n_i), .ds0_n_i(ds0_n_i), .ds1_n_i(ds1_n_i), .write_n_i(write_n_i),
    .iack_n_i(iack_n_i), .am_i(am_i), .addr_i(addr_i), .data_o(data_o),
    .data_oe_o(data_oe_o), .dtack_n_o(dtack_n_o), .irq_n_o(irq_n_o), .trig_o(trig_o),
    .reply_valid_i(reply_valid_i), .reply_ready_o(reply_ready_o));

// >>> wss_term_det.sv
/*
 Watches the accepted message bytes and flags a completed CR LF terminator.
 Assumes byte_valid_i pulses once per byte accepted from the commander.
*/
`timescale 1ns/10ps
`include "wss_consts.svh"
module wss_term_det (
    input wire logic clk_i,         // Clock
    input wire logic rst_i,         // Synchronous reset
    input wire logic clear_i,       // Forget any terminator
    input wire logic byte_valid_i,  // One accepted byte
    input wire logic [7:0] byte_i,  // Its value
    output logic term_o             // Last two bytes were CR LF
);
    typedef struct packed {
        logic last_cr;
        logic term;
    } wss_term_st_t;

    wss_term_st_t s_r;
    wss_term_st_t s_nxt;

    assign term_o = s_r.term;

    always_comb begin
        s_nxt = s_r;
        if (byte_valid_i) begin
            // Any further byte starts a new message, so the flag drops
            s_nxt.term = s_r.last_cr && (byte_i == `WSS_CHAR_LF);
            s_nxt.last_cr = (byte_i == `WSS_CHAR_CR);
        end
        if (clear_i) begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule
